// File: logic/wdu_watchdog.sv
// Purpose: 24-bit watchdog down-counter with keyed reload registers
// Assumes: cpu register strobes and refresh instruction are on ref_clk
// Notes: timeout outputs are one-cycle pulses; status flag is sticky
`timescale 1ns/1ns
module wdu_watchdog #(
  parameter int TICK_CYCLES = wdu_pkg::TICK_CYCLES
) (
  input wire logic ref_clk, // system clock, 100 MHz
  input wire logic reset_n, // async system reset, active low
  input wire logic [11:0] reg_addr, // register space address
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, valid cycle after reg_rd
  input wire logic watchdog_refresh_instr, // refresh instruction pulse
  input wire logic stop_recovery, // stop-mode recovery pulse
  input wire logic always_on_option, // high: run from reset, no disable
  input wire logic timeout_reset_select, // high: reset, low: interrupt
  output logic sys_reset_req, // timeout reset request pulse
  output logic irq_req // timeout interrupt request pulse
);
  // key walk of the unlock sequence; the fourth code is never entered
  typedef enum logic [1:0] {
    LOCKED,
    GOT_FIRST,
    UNLOCKED
  } wdu_lock_type;

  // oscillator-rate enable from the divider
  logic tick;

  // unlock walk, reload bytes and read data
  wdu_lock_type lock_reg;
  wdu_lock_type lock_next;
  logic [7:0] reload_upper_byte_reg;
  logic [7:0] reload_upper_byte_next;
  logic [7:0] reload_high_byte_reg;
  logic [7:0] reload_high_byte_next;
  logic [7:0] reload_low_byte_reg;
  logic [7:0] reload_low_byte_next;
  logic [7:0] rdata_next;

  // countdown, enable and timeout state
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  logic en_reg;
  logic en_next;
  logic timeout_flag_reg;
  logic timeout_flag_next;
  logic rst_req_next;
  logic irq_next;

  // decoded strobes and combined values
  logic [23:0] reload_value;
  logic ctrl_wr;
  logic refresh_ok;
  logic fire;

  // a one-cycle divider could never make a separate tick pulse
  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("wdu_watchdog: TICK_CYCLES must be at least 2");
    end
  endgenerate

  // oscillator-rate enable; each tick is 100 us, so reload/10 ms
  wdu_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_tick ( // RULE6
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  // write strobe aimed at one register address
  function automatic logic wr_hit(input logic wr, input logic [11:0] addr,
                                  input logic [11:0] target);
    return wr && (addr == target);
  endfunction : wr_hit

  // reload word and decoded strobes
  assign reload_value = {reload_upper_byte_reg, reload_high_byte_reg,
                         reload_low_byte_reg}; // RULE5
  assign ctrl_wr = wr_hit(reg_wr, reg_addr, wdu_pkg::ADDR_CTRL);
  // a late refresh must not mask a fault that is about to fire
  assign refresh_ok = watchdog_refresh_instr &&
                      (cnt_reg > wdu_pkg::REFRESH_FLOOR); // RULE7

  // unlock sequence; control writes only walk the key, nothing is stored
  always_comb begin
    lock_next = lock_reg;
    if (ctrl_wr) begin // RULE10
      unique case (lock_reg)
        LOCKED: begin
          lock_next = (reg_wdata == wdu_pkg::UNLOCK_KEY_FIRST) ?
                      GOT_FIRST : LOCKED; // RULE9
        end
        GOT_FIRST: begin
          lock_next = (reg_wdata == wdu_pkg::UNLOCK_KEY_SECOND) ?
                      UNLOCKED : LOCKED; // RULE9
        end
        UNLOCKED: begin
          lock_next = LOCKED;
        end
        default: begin
          lock_next = LOCKED; // stray code falls back to locked
        end
      endcase
    end else if (wr_hit(reg_wr, reg_addr, wdu_pkg::ADDR_LOW)) begin
      lock_next = LOCKED; // low byte closes the window
    end
  end

  // reload bytes, written only while unlocked
  always_comb begin
    reload_upper_byte_next = reload_upper_byte_reg;
    reload_high_byte_next = reload_high_byte_reg;
    reload_low_byte_next = reload_low_byte_reg;
    if (reg_wr && lock_reg == UNLOCKED) begin // RULE9
      if (reg_addr == wdu_pkg::ADDR_UPPER) begin
        reload_upper_byte_next = reg_wdata;
      end
      if (reg_addr == wdu_pkg::ADDR_HIGH) begin
        reload_high_byte_next = reg_wdata;
      end
      if (reg_addr == wdu_pkg::ADDR_LOW) begin
        reload_low_byte_next = reg_wdata;
      end
    end
  end

  // read mux; control address answers with reset status
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        wdu_pkg::ADDR_CTRL: begin
          rdata_next[wdu_pkg::STAT_TIMEOUT_BIT] = timeout_flag_reg; // RULE11
          rdata_next[wdu_pkg::STAT_ENABLED_BIT] = en_reg;
          rdata_next[wdu_pkg::STAT_UNLOCKED_BIT] = (lock_reg == UNLOCKED);
        end
        wdu_pkg::ADDR_UPPER: begin
          rdata_next = reload_upper_byte_reg;
        end
        wdu_pkg::ADDR_HIGH: begin
          rdata_next = reload_high_byte_reg;
        end
        wdu_pkg::ADDR_LOW: begin
          rdata_next = reload_low_byte_reg;
        end
        default: begin
          rdata_next = 8'h00; // unmapped reads as zero
        end
      endcase
    end
  end

  // register bank for the unlock walk, reload bytes and read data
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_reg <= LOCKED;
      reload_upper_byte_reg <= wdu_pkg::RST_UPPER;
      reload_high_byte_reg <= wdu_pkg::RST_HIGH;
      reload_low_byte_reg <= wdu_pkg::RST_LOW;
      reg_rdata <= 8'h00;
    end else begin
      lock_reg <= lock_next;
      reload_upper_byte_reg <= reload_upper_byte_next;
      reload_high_byte_reg <= reload_high_byte_next;
      reload_low_byte_reg <= reload_low_byte_next;
      reg_rdata <= rdata_next;
    end
  end

  // countdown, enable and timeout; refresh beats the tick in a cycle
  always_comb begin
    en_next = en_reg;
    cnt_next = cnt_reg;
    fire = 1'b0;
    if (always_on_option) begin
      en_next = 1'b1; // RULE4
    end else if (stop_recovery) begin
      en_next = 1'b0; // RULE13
    end
    if (!en_reg) begin
      cnt_next = reload_value; // off: stays primed for a fresh start
      if (watchdog_refresh_instr) begin
        en_next = 1'b1; // RULE4
      end
    end else if (refresh_ok) begin
      cnt_next = reload_value; // RULE14
    end else if (tick) begin // RULE3
      if (cnt_reg <= wdu_pkg::TERMINAL) begin
        fire = 1'b1; // RULE1
        cnt_next = reload_value; // single shot, then a new period
      end else begin
        cnt_next = cnt_reg - 24'h000001;
      end
    end
    // switching off re-primes the count for the next start
    if (en_next == 1'b0 && en_reg == 1'b1) begin
      cnt_next = reload_value;
    end
    rst_req_next = fire && timeout_reset_select; // RULE12
    irq_next = fire && !timeout_reset_select; // RULE12
    timeout_flag_next = timeout_flag_reg || fire; // sticky until reset
  end

  // countdown registers; reload values below the minimum are not screened,
  // keeping them in range is left to the software
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_reg <= 1'b0;
      cnt_reg <= {wdu_pkg::RST_UPPER, wdu_pkg::RST_HIGH, wdu_pkg::RST_LOW};
      timeout_flag_reg <= 1'b0;
      sys_reset_req <= 1'b0;
      irq_req <= 1'b0;
    end else begin
      en_reg <= en_next;
      cnt_reg <= cnt_next;
      timeout_flag_reg <= timeout_flag_next;
      sys_reset_req <= rst_req_next;
      irq_req <= irq_next;
    end
  end
endmodule : wdu_watchdog

// File: logic/wdu_pkg.sv
// Purpose: constants shared by the watchdog down-counter and its divider
// Assumes: 100 MHz ref_clk, 8-bit register space with 12-bit addresses
// Notes: option inputs are static levels from the option store
//
// Contract
// RULE1 - at terminal count the watchdog fires once: reset or interrupt
// RULE2 - counter advances at a dedicated 10 kHz rate, not system rate
// RULE3 - only on or off; once on it counts until refreshed or timed out
// RULE4 - enabled by refresh instruction or always-on option right after reset
// RULE5 - 24-bit down-counter reloads from upper, high, low reload bytes
// RULE6 - timeout in milliseconds equals reload value divided by ten
// RULE7 - refresh is ignored once the count has reached 000002H
// RULE8 - software never loads a reload value below 000004H
// RULE9 - reload bytes writable only after 55H then AAH at control address
// RULE10 - unlock writes store nothing at the control address
// RULE11 - reads at control address FF0H return reset status instead
// RULE12 - timeout-select option chooses interrupt when clear, reset when set
// RULE13 - always-on cannot be disabled; else only reset or stop recovery
// RULE14 - allowed refresh reloads the counter and restarts the countdown
package wdu_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'hFF0;
  localparam logic [11:0] ADDR_UPPER = 12'hFF1;
  localparam logic [11:0] ADDR_HIGH = 12'hFF2;
  localparam logic [11:0] ADDR_LOW = 12'hFF3;
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
  localparam logic [7:0] RST_UPPER = 8'hFF;
  localparam logic [7:0] RST_HIGH = 8'hFF;
  localparam logic [7:0] RST_LOW = 8'hFF;
  localparam logic [23:0] REFRESH_FLOOR = 24'h000002;
  localparam logic [23:0] MIN_RELOAD = 24'h000004;
  localparam logic [23:0] TERMINAL = 24'h000001;
  localparam int STAT_TIMEOUT_BIT = 7;
  localparam int STAT_ENABLED_BIT = 6;
  localparam int STAT_UNLOCKED_BIT = 5;
  localparam int CLK_FREQ_HZ = 100000000;
  localparam int RC_FREQ_HZ = 10000;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / RC_FREQ_HZ;
endpackage : wdu_pkg

// File: logic/wdu_tick_div.sv
// Purpose: one-cycle enable pulse at the watchdog oscillator rate
// Assumes: DIV of at least 2 system cycles
// Notes: stands in for the on-chip RC oscillator in a single clock domain
`timescale 1ns/1ns
module wdu_tick_div #(
  parameter int DIV = wdu_pkg::TICK_CYCLES
) (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // async reset, active low
  output logic tick // one pulse every DIV cycles
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic tick_next;

  generate
    if (DIV < 2) begin : g_bad_div
      $error("wdu_tick_div: DIV must be at least 2");
    end
  endgenerate

  // free-running divider, pulse on wrap
  always_comb begin
    tick_next = (cnt_reg == LAST); // RULE2
    cnt_next = tick_next ? '0 : cnt_reg + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end
endmodule : wdu_tick_div

// File: testbench/wdu_watchdog_props.sv
// Purpose: port checks for the watchdog down-counter
// Assumes: option inputs are static between resets
// Notes: bound onto every wdu_watchdog instance
`timescale 1ns/1ns
module wdu_watchdog_props #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [11:0] reg_addr, // address
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic watchdog_refresh_instr, // refresh
  input wire logic always_on_option, // always on
  input wire logic timeout_reset_select, // response select
  input wire logic sys_reset_req, // reset pulse
  input wire logic irq_req // interrupt pulse
);
  logic [1:0] flag_reg;
  logic [1:0] flag_next;
  // bit1 timeout seen, bit0 refresh seen since reset
  always_comb flag_next = flag_reg | {sys_reset_req | irq_req,
                                      watchdog_refresh_instr};
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) flag_reg <= 2'b00;
    else flag_reg <= flag_next;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // timeout requests are single pulses of the selected kind
  a_reset_one_cycle: assert property (
    sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");
  a_irq_one_cycle: assert property (irq_req |=> !irq_req)
    else $error("interrupt request longer than one cycle");
  a_select_reset: assert property (
    sys_reset_req |-> timeout_reset_select)
    else $error("reset request while interrupt selected");
  a_select_irq: assert property (irq_req |-> !timeout_reset_select)
    else $error("interrupt request while reset selected");
  a_off_quiet: assert property (!flag_reg[0] && !always_on_option
    |-> !(sys_reset_req | irq_req)) else $error("timeout while off");
  // read data stands one cycle after the strobe, zero otherwise
  a_read_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_status_layout: assert property ($past(reg_rd)
    && $past(reg_addr) == wdu_pkg::ADDR_CTRL |-> reg_rdata[4:0] == 5'h00)
    else $error("status unused bits set");
  a_status_enabled: assert property (
    $past(reg_rd) && $past(reset_n, 2)
    && $past(reg_addr) == wdu_pkg::ADDR_CTRL && always_on_option
    |-> reg_rdata[6]) else $error("always-on watchdog shown off");
  a_timeout_sticky: assert property ($past(reg_rd) && flag_reg[1]
    && $past(reg_addr) == wdu_pkg::ADDR_CTRL |-> reg_rdata[7])
    else $error("timeout flag lost");
  c_reset: cover property (sys_reset_req);
  c_irq: cover property (irq_req);
  c_unlocked: cover property ($past(reg_rd) && reg_rdata[5]);
endmodule : wdu_watchdog_props
bind wdu_watchdog wdu_watchdog_props #(.TICK_CYCLES(TICK_CYCLES))
  u_wdu_watchdog_props (.ref_clk, .reset_n, .reg_addr, .reg_rd, .reg_rdata,
  .watchdog_refresh_instr, .always_on_option, .timeout_reset_select,
  .sys_reset_req, .irq_req);

// File: testbench/wdu_watchdog_tb_top.sv
// Purpose: register and timeout sequences for the watchdog
// Assumes: tick every 4 cycles to keep timeouts short
// Notes: inputs move on the falling edge only
`timescale 1ns/1ns
module wdu_watchdog_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic watchdog_refresh_instr = 1'b0;
  logic stop_recovery = 1'b0;
  logic always_on_option = 1'b0;
  logic timeout_reset_select = 1'b1;
  logic [7:0] reg_rdata;
  logic sys_reset_req;
  logic irq_req;
  int fail_count = 0;
  int checked = 0;
  int n;
  wdu_watchdog #(.TICK_CYCLES(4)) u_wdu_watchdog (.ref_clk, .reset_n,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .watchdog_refresh_instr, .stop_recovery, .always_on_option,
    .timeout_reset_select, .sys_reset_req, .irq_req);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  // one strobe cycle, then one idle cycle so strobes never merge
  task automatic wr(logic [11:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(logic [11:0] a, logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    @(negedge ref_clk);
  endtask : rd
  task automatic poke(bit stop);
    if (stop) stop_recovery = 1'b1;
    else watchdog_refresh_instr = 1'b1;
    @(negedge ref_clk);
    stop_recovery = 1'b0;
    watchdog_refresh_instr = 1'b0;
  endtask : poke
  // bounded wait, then which request fired
  task automatic wait_pulse(logic [1:0] exp);
    n = 0;
    while (!(sys_reset_req | irq_req) && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk({6'h00, sys_reset_req, irq_req}, {6'h00, exp});
  endtask : wait_pulse
  task automatic quiet(int c);
    repeat (c) begin
      @(negedge ref_clk);
      chk({6'h00, sys_reset_req, irq_req}, 8'h00);
    end
  endtask : quiet
  task automatic wrap_up;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // sequence
  initial begin
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    rd(wdu_pkg::ADDR_CTRL, 8'h00);
    rd(wdu_pkg::ADDR_UPPER, wdu_pkg::RST_UPPER);
    wr(wdu_pkg::ADDR_HIGH, 8'h12);
    rd(wdu_pkg::ADDR_HIGH, wdu_pkg::RST_HIGH);
    wr(wdu_pkg::ADDR_CTRL, 8'hAA);
    wr(wdu_pkg::ADDR_CTRL, 8'h55);
    rd(wdu_pkg::ADDR_CTRL, 8'h00);
    wr(wdu_pkg::ADDR_CTRL, 8'h55); // wrong second key relocks
    wr(wdu_pkg::ADDR_HIGH, 8'h34);
    rd(wdu_pkg::ADDR_HIGH, wdu_pkg::RST_HIGH);
    wr(wdu_pkg::ADDR_CTRL, 8'h55);
    wr(wdu_pkg::ADDR_CTRL, 8'hAA);
    rd(wdu_pkg::ADDR_CTRL, 8'h20);
    wr(wdu_pkg::ADDR_UPPER, 8'h00);
    wr(wdu_pkg::ADDR_HIGH, 8'h00);
    wr(wdu_pkg::ADDR_LOW, 8'h06);
    wr(wdu_pkg::ADDR_HIGH, 8'h09);
    rd(wdu_pkg::ADDR_UPPER, 8'h00);
    rd(wdu_pkg::ADDR_HIGH, 8'h00);
    rd(wdu_pkg::ADDR_LOW, 8'h06);
    quiet(40);
    poke(1'b0);
    rd(wdu_pkg::ADDR_CTRL, 8'h40);
    wait_pulse(2'b10);
    chk({7'h00, n inside {[17:26]}}, 8'h01);
    rd(wdu_pkg::ADDR_CTRL, 8'hC0);
    repeat (6) begin
      poke(1'b0);
      quiet(12);
    end
    timeout_reset_select = 1'b0;
    wait_pulse(2'b01);
    // four ticks later the count is 2: refresh refused, expiry 7 cycles on
    quiet(16);
    poke(1'b0);
    wait_pulse(2'b01);
    chk(n[7:0], 8'h07);
    poke(1'b1);
    rd(wdu_pkg::ADDR_CTRL, 8'h80);
    quiet(40);
    always_on_option = 1'b1;
    reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    rd(wdu_pkg::ADDR_CTRL, 8'h40);
    poke(1'b1);
    rd(wdu_pkg::ADDR_CTRL, 8'h40);
    wrap_up();
  end
  // hang guard, well past the few hundred cycles needed
  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end
endmodule : wdu_watchdog_tb_top
